// File: cmd_query_pkg.sv
// Purpose: shared constants for the register command and query engine
// Assumes: byte-wide command stream, first byte of a frame is the register address
// Notes: payload bytes arrive most significant first

package cmd_query_pkg;

    // ----------------------------------------------------------------
    // command addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] SYNTH_CALIBRATE_CMD = 8'h1D;
    localparam logic [7:0] USER_NVM_BYTE_WRITE_CMD = 8'h1E;
    localparam logic [7:0] FREQ_PLAN_DEFAULT_CMD = 8'h1F;
    localparam logic [7:0] PARAM_QUERY = 8'h30;
    localparam logic [7:0] TEMP_QUERY = 8'h31;
    localparam logic [7:0] CONDITION_QUERY = 8'h32;
    localparam logic [7:0] IDENTITY_QUERY = 8'h33;
    localparam logic [7:0] CAL_NVM_READ_QUERY = 8'h34;
    localparam logic [7:0] USER_NVM_READ_QUERY = 8'h35;
    localparam logic [7:0] SPI_RESPONSE_SHIFT_OUT = 8'h36;

    // ----------------------------------------------------------------
    // payload byte counts after the address byte
    // ----------------------------------------------------------------
    localparam logic [2:0] LEN_ONE = 3'h1;
    localparam logic [2:0] LEN_NVM_WRITE = 3'h3;
    localparam logic [2:0] LEN_FREQ_PLAN = 3'h7;
    localparam logic [2:0] LEN_NVM_READ = 3'h3;
    localparam logic [2:0] LEN_SHIFT_OUT = 3'h7;

    // ----------------------------------------------------------------
    // response and field layout
    // ----------------------------------------------------------------
    localparam logic [3:0] RESP_BYTES = 4'h8;
    localparam logic [3:0] ACK_BYTES = 4'h1;
    localparam logic [7:0] ACK_VALUE = 8'h00;
    localparam int FREQ_SEL_LSB = 48;
    localparam logic [2:0] FREQ_SEL_MAX = 3'h3;
    localparam logic [47:0] FREQ_DEFAULT_RESET = 48'h0;

    // parameter query selectors
    localparam logic [3:0] SEL_RF = 4'h0;
    localparam logic [3:0] SEL_THIRD_IF = 4'h3;
    localparam logic [3:0] SEL_FIRST_OSC = 4'h4;
    localparam logic [3:0] SEL_SECOND_OSC = 4'h5;
    localparam logic [3:0] SEL_THIRD_OSC = 4'h6;
    localparam logic [3:0] SEL_ATTEN = 4'h7;
    localparam logic [3:0] SEL_CHAIN = 4'h8;

    // ----------------------------------------------------------------
    // engine states, gray along idle -> payload -> fetch
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PAYLOAD = 2'b01,
        ST_FETCH = 2'b11
    } eng_state_e;

endpackage

// File: host_model.sv
// Purpose: host controller writing frames and reading answers
// Assumes: all changes land by non-blocking assignment at a rising edge
// Notes: released write byte shows the inverse of its last value

module host_model (
    // clock
    input wire logic clk_in,
    // frame stream
    output logic wr_valid_out,
    output logic wr_first_out,
    output logic [7:0] wr_byte_out,
    // answer stream
    output logic rd_req_out,
    input wire logic rd_valid_in,
    input wire logic [7:0] rd_byte_in,
    input wire logic [3:0] rd_left_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr_valid_out = 1'b0;
        wr_first_out = 1'b0;
        wr_byte_out = 8'h00;
        rd_req_out = 1'b0;
    end

    // address byte then payload, most significant first
    task automatic send_frame(input logic [63:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            wr_valid_out <= 1'b1;
            wr_first_out <= (i == 0);
            wr_byte_out <= f[8*(n-1-i) +: 8];
            @(posedge clk_in);
        end
        wr_valid_out <= 1'b0;
        wr_first_out <= 1'b0;
        wr_byte_out <= ~wr_byte_out;
    endtask

    // bounded wait until the answer length is posted
    task automatic wait_left(input logic [3:0] want, output logic ok);
        int k;
        k = 0;
        while (rd_left_in !== want && k < 60) begin
            @(posedge clk_in);
            k++;
        end
        ok = (rd_left_in === want);
    endtask

    // request held for n edges; every byte is taken to empty the buffer
    task automatic get_bytes(input int n, output logic [63:0] v, output logic ok);
        v = 64'h0;
        ok = 1'b1;
        rd_req_out <= 1'b1;
        @(posedge clk_in);
        for (int i = 0; i < n; i++) begin
            if (i == n - 1) begin
                rd_req_out <= 1'b0;
            end
            @(posedge clk_in);
            ok = ok & (rd_valid_in === 1'b1);
            v = {v[55:0], rd_byte_in};
        end
    endtask
endmodule // host_model

// File: register_command_query_engine.sv
// Purpose: decode configuration commands and answer 8-byte queries
// Assumes: all inputs synchronous to clk_in, one write byte per wr_valid_in
// Notes: a new frame start aborts any frame or fetch in progress
//        memory reads walk the start address upward, one byte per cycle
//        only selectors 0..3 of a frequency plan become stored defaults
//
// Behaviour
// - calibrate command pulses the calibration start; its data byte is ignored
// - calibrate acknowledge is ready at once, calibration runs elsewhere
// - nvm write stores byte [7:0] at address [23:8]
// - every configuration command leaves one acknowledge byte to read
// - frequency plan: value [47:0], selector [50:48] picks RF or an IF
// - frequency plan value for selectors 0..3 is also kept as the default from then on
// - a query is a command write then a read of its prepared answer
// - every query answer is exactly eight bytes
// - answer bytes go out most significant byte first
// - parameter query selector [3:0] picks frequencies, attenuators or chain
// - temperature float in [31:0], upper word reads as zero
// - query frame: command and instruction written, eight bytes read
// - memory read queries return eight bytes from a 16-bit start
// - byte at start address lands in the answer's least significant byte
// - shift-out command only clocks data on spi; it changes nothing here

module register_command_query_engine #(
    parameter int NVM_AW = 16
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // command byte stream from host
    input wire logic wr_valid_in,
    input wire logic wr_first_in,
    input wire logic [7:0] wr_byte_in,
    // answer byte stream to host
    input wire logic rd_req_in,
    output logic rd_valid_out,
    output logic [7:0] rd_byte_out,
    output logic [3:0] rd_left_out,
    // synthesizer calibration
    output logic cal_start_out,
    // frequency plan application
    output logic freq_apply_out,
    output logic [2:0] freq_sel_out,
    output logic [47:0] freq_value_out,
    // live device values for queries
    input wire logic [63:0] first_local_osc_freq_in,
    input wire logic [63:0] second_local_osc_freq_in,
    input wire logic [63:0] third_local_osc_freq_in,
    input wire logic [63:0] atten_values_in,
    input wire logic [63:0] chain_config_in,
    input wire logic [31:0] temp_float_in,
    input wire logic [63:0] condition_in,
    output logic [3:0] identity_sel_out,
    input wire logic [63:0] identity_in,
    // calibration memory read port, data expected in the same cycle as the address
    output logic [15:0] cal_addr_out,
    input wire logic [7:0] cal_data_in
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        // frame decode
        cmd_query_pkg::eng_state_e st;
        logic [7:0] cmd;
        logic [2:0] need;
        logic [55:0] pl;

        // answer buffer, shifted out from the top
        logic [63:0] resp;
        logic [3:0] left;

        // memory fetch walk
        logic [3:0] idx;
        logic [15:0] base;

        // frequency plan defaults, one per selector 0..3
        logic [3:0] [47:0] defaults;

        // user memory write request, applied one cycle later
        logic nvm_we;
        logic [NVM_AW-1:0] nvm_addr;
        logic [7:0] nvm_data;

        // registered copies of the outputs
        logic rd_valid;
        logic [7:0] rd_byte;
        logic cal_start;
        logic freq_apply;
        logic [2:0] freq_sel;
        logic [47:0] freq_value;
        logic [3:0] identity_sel;
        logic [15:0] cal_addr;
    } eng_s;

    // state register and its next value
    eng_s s_r;
    eng_s s_nxt;

    // user memory; shrink NVM_AW to keep simulation light
    logic [7:0] nvm_mem [0:(1<<NVM_AW)-1];
    logic [7:0] nvm_q;
    logic [55:0] pl_new;
    logic [7:0] fetch_byte;

    // ----------------------------------------------------------------
    // command lengths
    // ----------------------------------------------------------------
    // payload length of each command; unknown commands swallow one byte
    function automatic logic [2:0] cmd_len(input logic [7:0] c);
        case (c)
            cmd_query_pkg::USER_NVM_BYTE_WRITE_CMD: cmd_len = cmd_query_pkg::LEN_NVM_WRITE;
            cmd_query_pkg::FREQ_PLAN_DEFAULT_CMD: cmd_len = cmd_query_pkg::LEN_FREQ_PLAN;
            cmd_query_pkg::CAL_NVM_READ_QUERY: cmd_len = cmd_query_pkg::LEN_NVM_READ;
            cmd_query_pkg::USER_NVM_READ_QUERY: cmd_len = cmd_query_pkg::LEN_NVM_READ;
            cmd_query_pkg::SPI_RESPONSE_SHIFT_OUT: cmd_len = cmd_query_pkg::LEN_SHIFT_OUT;
            default: cmd_len = cmd_query_pkg::LEN_ONE;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // user memory
    // ----------------------------------------------------------------
    // no reset on the array: it models nonvolatile storage
    always_ff @(posedge clk_in) begin
        if (s_r.nvm_we) begin
            nvm_mem[s_r.nvm_addr] <= s_r.nvm_data;
        end
    end

    // read follows the registered address combinationally, so data is valid in the same cycle
    assign nvm_q = nvm_mem[s_r.nvm_addr];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // one frame at a time; read side and write side share the answer buffer
    always_comb begin
        s_nxt = s_r;
        pl_new = {s_r.pl[47:0], wr_byte_in};
        fetch_byte = (s_r.cmd == cmd_query_pkg::CAL_NVM_READ_QUERY) ? cal_data_in : nvm_q;
        s_nxt.rd_valid = 1'b0;
        s_nxt.cal_start = 1'b0;
        s_nxt.freq_apply = 1'b0;
        s_nxt.nvm_we = 1'b0;

        // answer bytes leave from the top of the buffer
        if (rd_req_in && s_r.left != 4'h0) begin
            s_nxt.rd_valid = 1'b1;
            s_nxt.rd_byte = s_r.resp[63:56];
            s_nxt.resp = {s_r.resp[55:0], 8'h00};
            s_nxt.left = s_r.left - 4'h1;
        end

        // gather the answer of a query
        if (s_r.st == cmd_query_pkg::ST_FETCH) begin
            case (s_r.cmd)
                // memory reads: address goes out, its byte returns a cycle later
                cmd_query_pkg::CAL_NVM_READ_QUERY,
                cmd_query_pkg::USER_NVM_READ_QUERY: begin
                    if (s_r.idx != 4'h0) begin
                        s_nxt.resp[8*(s_r.idx-4'h1) +: 8] = fetch_byte;
                    end
                    if (s_r.idx == cmd_query_pkg::RESP_BYTES) begin
                        s_nxt.left = cmd_query_pkg::RESP_BYTES;
                        s_nxt.st = cmd_query_pkg::ST_IDLE;
                    end else begin
                        s_nxt.cal_addr = 16'(s_r.base + 16'(s_r.idx));
                        s_nxt.nvm_addr = NVM_AW'(s_r.base + 16'(s_r.idx));
                        s_nxt.idx = s_r.idx + 4'h1;
                    end
                end
                // other queries settle in one cycle, no walk needed
                cmd_query_pkg::PARAM_QUERY: begin
                    case (s_r.pl[3:0])
                        cmd_query_pkg::SEL_FIRST_OSC: s_nxt.resp = first_local_osc_freq_in;
                        cmd_query_pkg::SEL_SECOND_OSC: s_nxt.resp = second_local_osc_freq_in;
                        cmd_query_pkg::SEL_THIRD_OSC: s_nxt.resp = third_local_osc_freq_in;
                        cmd_query_pkg::SEL_ATTEN: s_nxt.resp = atten_values_in;
                        cmd_query_pkg::SEL_CHAIN: s_nxt.resp = chain_config_in;
                        default: begin
                            if (s_r.pl[3:0] <= cmd_query_pkg::SEL_THIRD_IF) begin
                                s_nxt.resp = {16'h0000, s_r.defaults[s_r.pl[1:0]]};
                            end else begin
                                s_nxt.resp = 64'h0000_0000_0000_0000;
                            end
                        end
                    endcase
                    s_nxt.left = cmd_query_pkg::RESP_BYTES;
                    s_nxt.st = cmd_query_pkg::ST_IDLE;
                end
                cmd_query_pkg::TEMP_QUERY: begin
                    s_nxt.resp = {32'h0000_0000, temp_float_in};
                    s_nxt.left = cmd_query_pkg::RESP_BYTES;
                    s_nxt.st = cmd_query_pkg::ST_IDLE;
                end
                cmd_query_pkg::CONDITION_QUERY: begin
                    s_nxt.resp = condition_in;
                    s_nxt.left = cmd_query_pkg::RESP_BYTES;
                    s_nxt.st = cmd_query_pkg::ST_IDLE;
                end
                default: begin
                    s_nxt.resp = identity_in; // selector was registered last cycle
                    s_nxt.left = cmd_query_pkg::RESP_BYTES;
                    s_nxt.st = cmd_query_pkg::ST_IDLE;
                end
            endcase
        end

        // a frame start always wins, so a confused host can resync
        if (wr_valid_in && wr_first_in) begin
            s_nxt.cmd = wr_byte_in;
            s_nxt.need = cmd_len(wr_byte_in);
            s_nxt.pl = 56'h0;
            s_nxt.st = cmd_query_pkg::ST_PAYLOAD;
        end else if (wr_valid_in && s_r.st == cmd_query_pkg::ST_PAYLOAD) begin
            s_nxt.pl = pl_new;
            s_nxt.need = s_r.need - 3'h1;
            if (s_r.need == 3'h1) begin
                s_nxt.st = cmd_query_pkg::ST_IDLE;
                case (s_r.cmd)
                    cmd_query_pkg::SYNTH_CALIBRATE_CMD: begin
                        s_nxt.cal_start = 1'b1;
                        s_nxt.resp = {cmd_query_pkg::ACK_VALUE, 56'h0};
                        s_nxt.left = cmd_query_pkg::ACK_BYTES;
                    end
                    cmd_query_pkg::USER_NVM_BYTE_WRITE_CMD: begin
                        s_nxt.nvm_we = 1'b1;
                        s_nxt.nvm_data = pl_new[7:0];
                        s_nxt.nvm_addr = NVM_AW'(pl_new[23:8]);
                        s_nxt.resp = {cmd_query_pkg::ACK_VALUE, 56'h0};
                        s_nxt.left = cmd_query_pkg::ACK_BYTES;
                    end
                    cmd_query_pkg::FREQ_PLAN_DEFAULT_CMD: begin
                        // selectors above IF3 are acknowledged but not applied
                        if (pl_new[50:48] <= cmd_query_pkg::FREQ_SEL_MAX) begin
                            s_nxt.freq_apply = 1'b1;
                            s_nxt.freq_sel = pl_new[50:48];
                            s_nxt.freq_value = pl_new[47:0];
                            s_nxt.defaults[pl_new[49:48]] = pl_new[47:0];
                        end
                        s_nxt.resp = {cmd_query_pkg::ACK_VALUE, 56'h0};
                        s_nxt.left = cmd_query_pkg::ACK_BYTES;
                    end
                    cmd_query_pkg::PARAM_QUERY,
                    cmd_query_pkg::TEMP_QUERY,
                    cmd_query_pkg::CONDITION_QUERY,
                    cmd_query_pkg::IDENTITY_QUERY,
                    cmd_query_pkg::CAL_NVM_READ_QUERY,
                    cmd_query_pkg::USER_NVM_READ_QUERY: begin
                        // a new request drops whatever answer was left unread
                        s_nxt.left = 4'h0;
                        s_nxt.resp = 64'h0000_0000_0000_0000;
                        s_nxt.identity_sel = pl_new[3:0];
                        s_nxt.base = pl_new[15:0];
                        s_nxt.idx = 4'h0;
                        s_nxt.st = cmd_query_pkg::ST_FETCH;
                    end
                    default: begin
                        s_nxt.st = cmd_query_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_r <= '0;
            s_r.st <= cmd_query_pkg::ST_IDLE;
            // defaults return to their reset value, nothing kept across reset
            for (int i = 0; i < 4; i++) begin
                s_r.defaults[i] <= cmd_query_pkg::FREQ_DEFAULT_RESET;
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from the state register
    // ----------------------------------------------------------------
    // answer stream
    assign rd_valid_out = s_r.rd_valid;
    assign rd_byte_out = s_r.rd_byte;
    assign rd_left_out = s_r.left;

    // calibration and frequency plan
    assign cal_start_out = s_r.cal_start;
    assign freq_apply_out = s_r.freq_apply;
    assign freq_sel_out = s_r.freq_sel;
    assign freq_value_out = s_r.freq_value;

    // query side selectors, held until the next query
    assign identity_sel_out = s_r.identity_sel;
    assign cal_addr_out = s_r.cal_addr;

endmodule // register_command_query_engine

// File: register_command_query_engine_properties.sv
// Purpose: port-level assertions for the command and query engine
// Assumes: single clock domain, async active-low reset
// Notes: bound onto every instance of the engine

module register_command_query_engine_properties (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // host side
    input wire logic wr_valid_in,
    input wire logic rd_req_in,
    input wire logic rd_valid_out,
    input wire logic [3:0] rd_left_out,
    // device side
    input wire logic cal_start_out,
    input wire logic freq_apply_out,
    input wire logic [2:0] freq_sel_out,
    input wire logic [47:0] freq_value_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    // calibration start comes with its ack already waiting
    chk_cal_acked: assert property (cal_start_out |-> rd_left_out == 4'h1)
        else $error("calibration start without pending ack");
    chk_cal_pulse: assert property (cal_start_out |=> !cal_start_out)
        else $error("calibration start wider than one cycle");
    // reads are honoured only while bytes remain
    chk_read_honoured: assert property (rd_req_in && rd_left_out != 4'h0 |=> rd_valid_out)
        else $error("read request not answered");
    chk_read_refused: assert property (rd_req_in && rd_left_out == 4'h0 |=> !rd_valid_out)
        else $error("read answered with nothing pending");
    chk_valid_cause: assert property (rd_valid_out |-> $past(rd_req_in))
        else $error("read valid without a request");
    // write bytes excluded: a completing frame may clear or reload the count
    chk_left_step: assert property (rd_req_in && !wr_valid_in && rd_left_out != 4'h0
        |=> rd_left_out == $past(rd_left_out) - 4'h1)
        else $error("pending byte count did not step down");
    chk_left_load: assert property (rd_left_out != 4'h0 && $past(rd_left_out) == 4'h0
        |-> rd_left_out == 4'h1 || rd_left_out == 4'h8)
        else $error("answer length is neither one nor eight");
    chk_freq_range: assert property (freq_apply_out |-> freq_sel_out <= 3'h3)
        else $error("frequency applied with bad selector");
    chk_freq_held: assert property ($changed(freq_value_out) |-> freq_apply_out)
        else $error("frequency value moved without apply");
endmodule // register_command_query_engine_properties

bind register_command_query_engine register_command_query_engine_properties u_props (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .wr_valid_in(wr_valid_in),
    .rd_req_in(rd_req_in), .rd_valid_out(rd_valid_out), .rd_left_out(rd_left_out),
    .cal_start_out(cal_start_out), .freq_apply_out(freq_apply_out),
    .freq_sel_out(freq_sel_out), .freq_value_out(freq_value_out));

// File: register_command_query_engine_test.sv
// Purpose: self-checking bench for the command and query engine
// Assumes: host_model drives the frame and answer streams
// Notes: live values other than identity track one variable so each of those inputs moves

module register_command_query_engine_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [47:0] FBASE = 48'h0123_4567_89A0;
    logic clk, reset_n, wr_valid, wr_first, rd_req, rd_valid, cal_start, freq_apply;
    logic [7:0] wr_byte, rd_byte, cal_data;
    logic [3:0] rd_left, identity_sel;
    logic [2:0] freq_sel, sel;
    logic [47:0] freq_value;
    logic [15:0] cal_addr;
    logic [63:0] live, v, e;
    int fails = 0;
    int comparisons = 0;

    // combinational calibration memory, contents derived from address
    assign cal_data = cal_addr[7:0] ^ 8'hA5;

    register_command_query_engine u_register_command_query_engine (
        .clk_in(clk), .reset_n_in(reset_n), .wr_valid_in(wr_valid), .wr_first_in(wr_first),
        .wr_byte_in(wr_byte), .rd_req_in(rd_req), .rd_valid_out(rd_valid),
        .rd_byte_out(rd_byte), .rd_left_out(rd_left), .cal_start_out(cal_start),
        .freq_apply_out(freq_apply), .freq_sel_out(freq_sel), .freq_value_out(freq_value),
        .first_local_osc_freq_in(live + 64'h1), .second_local_osc_freq_in(live + 64'h2),
        .third_local_osc_freq_in(live + 64'h3), .atten_values_in(live + 64'h4),
        .chain_config_in(live + 64'h5), .temp_float_in(live[31:0] ^ 32'h4228_0000),
        .condition_in(~live), .identity_sel_out(identity_sel),
        .identity_in({16{identity_sel}}), .cal_addr_out(cal_addr), .cal_data_in(cal_data));

    host_model u_host_model (
        .clk_in(clk), .wr_valid_out(wr_valid), .wr_first_out(wr_first), .wr_byte_out(wr_byte),
        .rd_req_out(rd_req), .rd_valid_in(rd_valid), .rd_byte_in(rd_byte), .rd_left_in(rd_left));

    // clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (fails == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic ack_read();
        logic ok;
        u_host_model.wait_left(4'h1, ok);
        check("ack ready", ok, 1);
        u_host_model.get_bytes(1, v, ok);
        check("ack byte", {ok, v[7:0]}, 9'h100);
    endtask

    task automatic query(input logic [63:0] f, input int n);
        logic ok;
        u_host_model.send_frame(f, n);
        u_host_model.wait_left(4'h8, ok);
        check("answer ready", ok, 1);
        u_host_model.get_bytes(8, v, ok);
        check("answer valid", ok, 1);
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        live = 64'h0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        u_host_model.send_frame(64'h1DFF, 2);
        @(posedge clk);
        check("cal start", {cal_start, rd_left}, 5'h11);
        ack_read();
        // selector 5 is out of range: acked but never applied
        for (int s = 0; s < 5; s++) begin
            sel = (s == 4) ? 3'h5 : 3'(s);
            u_host_model.send_frame({8'h1F, 5'h0, sel, FBASE + s}, 8);
            @(posedge clk);
            check("freq apply", freq_apply, s < 4);
            if (s < 4) check("freq set", {freq_sel, freq_value}, {sel, FBASE + s});
            ack_read();
        end
        for (int p = 0; p < 10; p++) begin
            live <= {16{4'(p)}};
            e = (p < 4) ? {16'h0, FBASE + p} : (p < 9) ? {16{4'(p)}} + 64'(p - 3) : 64'h0;
            query({8'h30, 4'hA, 4'(p)}, 2);
            check("param answer", v, e);
        end
        query(64'h3100, 2);
        check("temp answer", v, {32'h0, live[31:0] ^ 32'h4228_0000});
        query(64'h3200, 2);
        check("condition answer", v, ~live);
        query(64'h3302, 2);
        check("identity select", identity_sel, 4'h2);
        check("identity answer", v, {16{4'h2}});
        for (int i = 0; i < 8; i++) begin
            u_host_model.send_frame({8'h1E, 16'(16'h1230 + i), 8'(8'hC0 + i)}, 4);
            ack_read();
            e[8*i +: 8] = 8'(8'hC0 + i);
        end
        query({8'h35, 8'h00, 16'h1230}, 4);
        check("user memory answer", v, e);
        for (int i = 0; i < 8; i++) e[8*i +: 8] = 8'(8'h40 + i) ^ 8'hA5;
        query({8'h34, 8'h00, 16'h0040}, 4);
        check("cal memory answer", v, e);
        u_host_model.send_frame({8'h36, 56'h0}, 8);
        repeat (12) @(posedge clk);
        check("shift out pending", rd_left, 0);
        // mid-run reset: outputs and stored defaults go back to zero
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        check("reset outputs", {freq_sel, freq_value, identity_sel}, 55'h0);
        query(64'h3000, 2);
        check("param after reset", v, 64'h0);
        report_and_stop();
    end

    // watchdog, well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        report_and_stop();
    end
endmodule // register_command_query_engine_test
